// ===== src/ext_irq_pkg.sv
/*
 * Constants for the external interrupt pin block: register offsets, bit
 * positions, reset values and event bit layout.
 * Assumes an 8-bit register port with byte-wide offsets.
 */
package ext_irq_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [ADDR_W-1:0] OFS_OPTION         = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SECOND_OPTION  = 8'h01;
	localparam logic [ADDR_W-1:0] OFS_CONDITION_CODE = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_SERIAL_PERIPH  = 8'h03;
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_EVENT_MASK     = 8'h05;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int MASKABLE_EDGE_BIT       = 5;
	localparam int NONMASKABLE_EDGE_BIT    = 1;
	localparam int NONMASKABLE_MASK_BIT    = 6;
	localparam int MASKABLE_MASK_BIT       = 4;
	localparam int MASKABLE_PIN_LEVEL_BIT    = 1;
	localparam int NONMASKABLE_PIN_LEVEL_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic RST_EDGE_MODE      = 1'b0;
	localparam logic RST_MASKABLE_MASK  = 1'b1;
	localparam logic RST_NONMASK_MASK   = 1'b1;
	localparam logic RST_PIN_LEVEL      = 1'b1;
	localparam logic [DATA_W-1:0] RST_EVENT_MASK = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// event status layout
	localparam int EVT_W               = 4;
	localparam int EVT_MASKABLE_FALL   = 0;
	localparam int EVT_NONMASK_FALL    = 1;
	localparam int EVT_MASKABLE_TAKEN  = 2;
	localparam int EVT_NONMASK_TAKEN   = 3;

	localparam int SYNC_STAGES_DEFAULT = 2;

endpackage : ext_irq_pkg

// ===== src/request_detector.sv
/*
 * One request pin: synchroniser, falling-edge detector, pending latch and
 * level/edge trigger selection.
 * Assumes an active-low asynchronous pin pulled high when idle.
 */
`timescale 1ns/1ps

module request_detector #(
	parameter int SYNC_STAGES = ext_irq_pkg::SYNC_STAGES_DEFAULT
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// pin and control
	input  wire logic pin_n,
	input  wire logic edge_mode,
	input  wire logic take,
	// results
	output logic      pin_level,
	output logic      active,
	output logic      fall_seen
);

	generate
		if (SYNC_STAGES < 2)
		begin : g_bad_stages
			$error("request_detector needs at least two sync stages");
		end
	endgenerate

	logic [SYNC_STAGES-1:0] sync_q;
	logic [SYNC_STAGES-1:0] next_sync_q;
	logic                   last_level;
	logic                   next_last_level;
	logic                   pending;
	logic                   next_pending;

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		next_sync_q     = {sync_q[SYNC_STAGES-2:0], pin_n};
		next_last_level = sync_q[SYNC_STAGES-1];
		next_pending    = pending;
		if (take || !edge_mode)
			next_pending = 1'b0;
		if (edge_mode && fall_seen)
			next_pending = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_q     <= {SYNC_STAGES{ext_irq_pkg::RST_PIN_LEVEL}};
			last_level <= ext_irq_pkg::RST_PIN_LEVEL;
			pending    <= 1'b0;
		end
		else
		begin
			sync_q     <= next_sync_q;
			last_level <= next_last_level;
			pending    <= next_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign pin_level = sync_q[SYNC_STAGES-1];
	assign fall_seen = last_level && !sync_q[SYNC_STAGES-1];
	assign active    = edge_mode ? pending : !pin_level;

endmodule : request_detector

// ===== src/event_status.sv
/*
 * Sticky event status with read-to-clear, mask register and one level
 * interrupt output.
 * Assumes one-cycle event pulses and a one-cycle read strobe.
 */
`timescale 1ns/1ps

module event_status #(
	parameter int WIDTH = ext_irq_pkg::EVT_W
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	// events
	input  wire logic [WIDTH-1:0] set_evt,
	// software side
	input  wire logic             read_clear,
	input  wire logic             mask_wr,
	input  wire logic [WIDTH-1:0] mask_wdata,
	// state
	output logic      [WIDTH-1:0] status,
	output logic      [WIDTH-1:0] mask,
	output logic                  irq
);

	generate
		if (WIDTH < 1 || WIDTH > ext_irq_pkg::DATA_W)
		begin : g_bad_width
			$error("event_status width must fit the data bus");
		end
	endgenerate

	logic [WIDTH-1:0] next_status;
	logic [WIDTH-1:0] next_mask;
	logic             next_irq;

	always_comb
	begin
		// set wins over the read clear
		next_status = (status & ~{WIDTH{read_clear}}) | set_evt;
		next_mask   = mask_wr ? mask_wdata : mask;
		next_irq    = |(next_status & next_mask);
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			status <= '0;
			mask   <= ext_irq_pkg::RST_EVENT_MASK[WIDTH-1:0];
			irq    <= 1'b0;
		end
		else
		begin
			status <= next_status;
			mask   <= next_mask;
			irq    <= next_irq;
		end
	end

endmodule : event_status

// ===== src/external_interrupt_pins.sv
/*
 * External interrupt request pins: maskable and nonmaskable request
 * inputs with trigger selection, mask bits, pin level readback and a
 * request/take handshake toward the processor core.
 * Assumes one 125 MHz clock, asynchronous active-low pins with external
 * pull-ups, and a register master that keeps strobes one cycle long.
 */
// Our own choices: the address map and the address-and-strobe port.
// Behaviour
// - maskable input selectable falling edge or low level
// - nonmaskable input selectable falling edge or low level
// - both inputs level sensitive after reset
// - level bit reads maskable pin level
// - maskable mask bit blocks maskable requests
// - level bit reads nonmaskable pin level
// - reset sets nonmaskable mask; cleared by software
// - held-low level line reinterrupts once unmasked
`timescale 1ns/1ps

module external_interrupt_pins #(
	parameter int SYNC_STAGES = ext_irq_pkg::SYNC_STAGES_DEFAULT
) (
	// clock and reset
	input  wire logic                           sys_clk,
	input  wire logic                           rstn,
	// request pins, active low
	input  wire logic                           maskable_request_pin_n,
	input  wire logic                           nonmaskable_request_pin_n,
	// register port
	input  wire logic [ext_irq_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [ext_irq_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [ext_irq_pkg::DATA_W-1:0] reg_rdata,
	// processor core handshake
	output logic                                maskable_int_req,
	output logic                                nonmaskable_int_req,
	input  wire logic                           maskable_take,
	input  wire logic                           nonmaskable_take,
	// event interrupt
	output logic                                event_irq
);

	localparam int DW = ext_irq_pkg::DATA_W;
	localparam int EW = ext_irq_pkg::EVT_W;

	// the pin path needs two flops before any logic reads it
	generate
		if (SYNC_STAGES < 2)
		begin : g_bad_stages
			$error("external_interrupt_pins needs at least two sync stages");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// state
	logic          maskable_edge_mode;
	logic          next_maskable_edge_mode;
	logic          nonmaskable_edge_mode;
	logic          next_nonmaskable_edge_mode;
	logic          maskable_mask;
	logic          next_maskable_mask;
	logic          nonmaskable_mask;
	logic          next_nonmaskable_mask;
	logic          next_maskable_int_req;
	logic          next_nonmaskable_int_req;
	logic [DW-1:0] next_reg_rdata;

	////////////////////////////////////////////////////////////////////////
	// detector results
	logic          maskable_level;
	logic          maskable_active;
	logic          maskable_fall;
	logic          nonmaskable_level;
	logic          nonmaskable_active;
	logic          nonmaskable_fall;
	logic          maskable_taken;
	logic          nonmaskable_taken;

	////////////////////////////////////////////////////////////////////////
	// event block wires
	logic [EW-1:0] evt_set;
	logic [EW-1:0] evt_status;
	logic [EW-1:0] evt_mask;
	logic          evt_read_clear;
	logic          evt_mask_wr;

	////////////////////////////////////////////////////////////////////////
	// register decode
	function automatic logic hit(
		input logic                           strobe,
		input logic [ext_irq_pkg::ADDR_W-1:0] addr,
		input logic [ext_irq_pkg::ADDR_W-1:0] ofs
	);
		hit = strobe && (addr == ofs);
	endfunction : hit

	logic wr_option;
	logic wr_second_option;
	logic wr_condition_code;

	assign wr_option         = hit(reg_wr, reg_addr, ext_irq_pkg::OFS_OPTION);
	assign wr_second_option  = hit(reg_wr, reg_addr, ext_irq_pkg::OFS_SECOND_OPTION);
	assign wr_condition_code = hit(reg_wr, reg_addr, ext_irq_pkg::OFS_CONDITION_CODE);
	assign evt_mask_wr       = hit(reg_wr, reg_addr, ext_irq_pkg::OFS_EVENT_MASK);
	assign evt_read_clear    = hit(reg_rd, reg_addr, ext_irq_pkg::OFS_EVENT_STATUS);

	////////////////////////////////////////////////////////////////////////
	// take only counts while the matching request is raised
	assign maskable_taken    = maskable_take && maskable_int_req;
	assign nonmaskable_taken = nonmaskable_take && nonmaskable_int_req;

	////////////////////////////////////////////////////////////////////////
	// pin detectors
	request_detector #(
		.SYNC_STAGES (SYNC_STAGES)
	) u_maskable (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.pin_n     (maskable_request_pin_n),
		.edge_mode (maskable_edge_mode),
		.take      (maskable_taken),
		.pin_level (maskable_level),
		.active    (maskable_active),
		.fall_seen (maskable_fall)
	);

	request_detector #(
		.SYNC_STAGES (SYNC_STAGES)
	) u_nonmaskable (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.pin_n     (nonmaskable_request_pin_n),
		.edge_mode (nonmaskable_edge_mode),
		.take      (nonmaskable_taken),
		.pin_level (nonmaskable_level),
		.active    (nonmaskable_active),
		.fall_seen (nonmaskable_fall)
	);

	////////////////////////////////////////////////////////////////////////
	// event status and mask
	always_comb
	begin
		evt_set                                   = '0;
		evt_set[ext_irq_pkg::EVT_MASKABLE_FALL]   = maskable_fall;
		evt_set[ext_irq_pkg::EVT_NONMASK_FALL]    = nonmaskable_fall;
		evt_set[ext_irq_pkg::EVT_MASKABLE_TAKEN]  = maskable_taken;
		evt_set[ext_irq_pkg::EVT_NONMASK_TAKEN]   = nonmaskable_taken;
	end

	event_status #(
		.WIDTH (EW)
	) u_events (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.set_evt    (evt_set),
		.read_clear (evt_read_clear),
		.mask_wr    (evt_mask_wr),
		.mask_wdata (reg_wdata[EW-1:0]),
		.status     (evt_status),
		.mask       (evt_mask),
		.irq        (event_irq)
	);

	////////////////////////////////////////////////////////////////////////
	// trigger selection
	always_comb
	begin
		next_maskable_edge_mode    = maskable_edge_mode;
		next_nonmaskable_edge_mode = nonmaskable_edge_mode;
		if (wr_option)
			next_maskable_edge_mode = reg_wdata[ext_irq_pkg::MASKABLE_EDGE_BIT];
		if (wr_second_option)
			next_nonmaskable_edge_mode = reg_wdata[ext_irq_pkg::NONMASKABLE_EDGE_BIT];
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			maskable_edge_mode    <= ext_irq_pkg::RST_EDGE_MODE;
			nonmaskable_edge_mode <= ext_irq_pkg::RST_EDGE_MODE;
		end
		else
		begin
			maskable_edge_mode    <= next_maskable_edge_mode;
			nonmaskable_edge_mode <= next_nonmaskable_edge_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mask bits
	always_comb
	begin
		next_maskable_mask    = maskable_mask;
		next_nonmaskable_mask = nonmaskable_mask;
		if (wr_condition_code)
		begin
			next_maskable_mask = reg_wdata[ext_irq_pkg::MASKABLE_MASK_BIT];
			// software may clear the nonmaskable mask, never set it
			if (!reg_wdata[ext_irq_pkg::NONMASKABLE_MASK_BIT])
				next_nonmaskable_mask = 1'b0;
		end
		// entering a handler masks further maskable requests;
		// a take in the cycle of a clearing write wins
		if (maskable_taken || nonmaskable_taken)
			next_maskable_mask = 1'b1;
		if (nonmaskable_taken)
			next_nonmaskable_mask = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			maskable_mask    <= ext_irq_pkg::RST_MASKABLE_MASK;
			nonmaskable_mask <= ext_irq_pkg::RST_NONMASK_MASK;
		end
		else
		begin
			maskable_mask    <= next_maskable_mask;
			nonmaskable_mask <= next_nonmaskable_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// requests toward the core, gated by the next mask values
	function automatic logic request_next(
		input logic active,
		input logic next_mask,
		input logic taken
	);
		request_next = active && !next_mask && !taken;
	endfunction : request_next

	always_comb
	begin
		next_maskable_int_req    = request_next(maskable_active, next_maskable_mask,
			maskable_taken);
		next_nonmaskable_int_req = request_next(nonmaskable_active, next_nonmaskable_mask,
			nonmaskable_taken);
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			maskable_int_req    <= 1'b0;
			nonmaskable_int_req <= 1'b0;
		end
		else
		begin
			maskable_int_req    <= next_maskable_int_req;
			nonmaskable_int_req <= next_nonmaskable_int_req;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data
	always_comb
	begin
		next_reg_rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				ext_irq_pkg::OFS_OPTION:
					next_reg_rdata[ext_irq_pkg::MASKABLE_EDGE_BIT] = maskable_edge_mode;
				ext_irq_pkg::OFS_SECOND_OPTION:
					next_reg_rdata[ext_irq_pkg::NONMASKABLE_EDGE_BIT] = nonmaskable_edge_mode;
				ext_irq_pkg::OFS_CONDITION_CODE:
				begin
					next_reg_rdata[ext_irq_pkg::MASKABLE_MASK_BIT]    = maskable_mask;
					next_reg_rdata[ext_irq_pkg::NONMASKABLE_MASK_BIT] = nonmaskable_mask;
				end
				ext_irq_pkg::OFS_SERIAL_PERIPH:
				begin
					next_reg_rdata[ext_irq_pkg::MASKABLE_PIN_LEVEL_BIT]    = maskable_level;
					next_reg_rdata[ext_irq_pkg::NONMASKABLE_PIN_LEVEL_BIT] = nonmaskable_level;
				end
				ext_irq_pkg::OFS_EVENT_STATUS:
					next_reg_rdata[EW-1:0] = evt_status;
				ext_irq_pkg::OFS_EVENT_MASK:
					next_reg_rdata[EW-1:0] = evt_mask;
				default:
					next_reg_rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data register, zero outside the cycle after a read
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= '0;
		else
			reg_rdata <= next_reg_rdata;
	end

endmodule : external_interrupt_pins

// ===== test/irq_sources.sv
/*
 * Two interrupt sources sharing one open-drain request line.
 * Assumes a pull-up on the line and a take pulse from the core.
 */
`timescale 1ns/1ps

module irq_sources (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	// source control
	input  wire logic [1:0] raise,
	input  wire logic       take,
	// shared line
	output logic            line_n
);
	logic [1:0] held;
	logic [1:0] next_held;

	////////////////////////////////////////////////////////////////////////
	// interlock: each source holds until one take acknowledges it
	always_comb
	begin
		next_held = (take ? (held & (held - 2'h1)) : held) | raise;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			held <= 2'h0;
		else
			held <= next_held;
	end

	// pull-down only, pull-up when all released
	assign line_n = ~|held;
endmodule : irq_sources

// ===== test/external_interrupt_pins_chk.sv
/*
 * Port assertions for the external interrupt pin block.
 * Assumes the default two-stage pin synchroniser.
 */
`timescale 1ns/1ps

module external_interrupt_pins_chk #(
	parameter int SYNC_STAGES = 2
) (
	// clock and reset
	input  wire logic                           sys_clk,
	input  wire logic                           rstn,
	// pins
	input  wire logic                           maskable_request_pin_n,
	input  wire logic                           nonmaskable_request_pin_n,
	// register port
	input  wire logic [ext_irq_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [ext_irq_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	input  wire logic [ext_irq_pkg::DATA_W-1:0] reg_rdata,
	// core handshake
	input  wire logic                           maskable_int_req,
	input  wire logic                           nonmaskable_int_req,
	input  wire logic                           maskable_take,
	input  wire logic                           nonmaskable_take,
	input  wire logic                           event_irq
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	logic [1:0] msk;
	logic [1:0] next_msk;
	logic       m_taken;
	logic       x_taken;

	assign m_taken = maskable_take & maskable_int_req;
	assign x_taken = nonmaskable_take & nonmaskable_int_req;

	////////////////////////////////////////////////////////////////////////
	// shadow of the two mask bits
	always_comb
	begin
		next_msk = msk;
		if (reg_wr && reg_addr == ext_irq_pkg::OFS_CONDITION_CODE)
		begin
			next_msk[0] = reg_wdata[ext_irq_pkg::MASKABLE_MASK_BIT];
			next_msk[1] = msk[1] & reg_wdata[ext_irq_pkg::NONMASKABLE_MASK_BIT];
		end
		if (m_taken || x_taken)
			next_msk[0] = 1'b1;
		if (x_taken)
			next_msk[1] = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			msk <= 2'h3;
		else
			msk <= next_msk;
	end

	////////////////////////////////////////////////////////////////////////
	sequence m_steady;
		$stable(maskable_request_pin_n)[*4];
	endsequence
	sequence x_steady;
		$stable(nonmaskable_request_pin_n)[*4];
	endsequence
	sequence spc_read;
		reg_rd && reg_addr == ext_irq_pkg::OFS_SERIAL_PERIPH;
	endsequence

	chk_rdata_idle:
		assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero");
	chk_unmapped_read:
		assert property (reg_rd && reg_addr > ext_irq_pkg::OFS_EVENT_MASK |=> reg_rdata == 8'h00)
			else $error("unmapped read not zero");
	chk_maskable_level:
		assert property (m_steady ##0 spc_read |=> reg_rdata[ext_irq_pkg::MASKABLE_PIN_LEVEL_BIT]
			== $past(maskable_request_pin_n)) else $error("maskable level bit wrong");
	chk_nonmask_level:
		assert property (x_steady ##0 spc_read |=> reg_rdata[ext_irq_pkg::NONMASKABLE_PIN_LEVEL_BIT]
			== $past(nonmaskable_request_pin_n)) else $error("nonmaskable level bit wrong");
	chk_imask_blocks:
		assert property (msk[0] |-> !maskable_int_req) else $error("maskable request while masked");
	chk_xmask_blocks:
		assert property (msk[1] |-> !nonmaskable_int_req) else $error("nonmaskable request while masked");
	chk_take_drops:
		assert property (m_taken |=> !maskable_int_req) else $error("maskable request after take");
	chk_nmi_take_drops:
		assert property (x_taken |=> !nonmaskable_int_req && !maskable_int_req)
			else $error("request after nonmaskable take");
endmodule : external_interrupt_pins_chk

bind external_interrupt_pins external_interrupt_pins_chk #(.SYNC_STAGES(SYNC_STAGES))
	i_external_interrupt_pins_chk (.sys_clk, .rstn, .maskable_request_pin_n, .nonmaskable_request_pin_n,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .maskable_int_req, .nonmaskable_int_req,
	.maskable_take, .nonmaskable_take, .event_irq);

// ===== test/tb_external_interrupt_pins.sv
/*
 * Self-checking bench for the external interrupt pin block.
 * Assumes the shared-line source model and the bound checker.
 */
`timescale 1ns/1ps

module tb_external_interrupt_pins;
	logic       sys_clk;
	logic       rstn;
	logic       reg_wr;
	logic       reg_rd;
	logic       event_irq;
	logic       m_n;
	logic       x_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [1:0] tk;
	logic [1:0] req;
	logic [1:0] rs [2];
	integer     seed;
	integer     error_cnt;
	integer     tests_run;
	integer     cyc = 0;

	irq_sources i_irq_sources (.sys_clk(sys_clk), .rstn(rstn), .raise(rs[0]), .take(tk[0]), .line_n(m_n));
	irq_sources i_irq_sources_nmi (.sys_clk(sys_clk), .rstn(rstn), .raise(rs[1]), .take(tk[1]), .line_n(x_n));

	external_interrupt_pins i_external_interrupt_pins (
		.sys_clk(sys_clk), .rstn(rstn),
		.maskable_request_pin_n(m_n), .nonmaskable_request_pin_n(x_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .maskable_int_req(req[0]), .nonmaskable_int_req(req[1]),
		.maskable_take(tk[0]), .nonmaskable_take(tk[1]), .event_irq(event_irq)
	);

	////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd

	task take(input int l);
		@(posedge sys_clk);
		tk[l] <= 1'b1;
		@(posedge sys_clk);
		tk[l] <= 1'b0;
		#1 chk(8'(req[l]), 8'h00);
	endtask : take

	task wait_req(input int l);
		int n;
		n = 0;
		while (req[l] !== 1'b1 && n < 12)
		begin
			@(posedge sys_clk);
			#1 n = n + 1;
		end
		chk(8'(req[l]), 8'h01);
	endtask : wait_req

	function automatic logic [7:0] mode_byte(input int l, input logic e);
		mode_byte = 8'h00;
		if (e)
			mode_byte[l ? ext_irq_pkg::NONMASKABLE_EDGE_BIT : ext_irq_pkg::MASKABLE_EDGE_BIT] = 1'b1;
	endfunction : mode_byte

	// level mode: two sources share the line; edge mode: one source only
	task run(input int l, input logic e);
		logic [7:0] mode;
		mode = mode_byte(l, e);
		wr(l ? 8'h01 : 8'h00, mode);
		rd(l ? 8'h01 : 8'h00, mode);
		wr(8'h05, e ? 8'h0F : 8'h00);
		wr(8'h02, 8'h00);
		@(posedge sys_clk);
		rs[l] <= e ? 2'b01 : 2'b11;
		@(posedge sys_clk);
		rs[l] <= 2'b00;
		wait_req(l);
		take(l);
		chk(8'(event_irq), 8'(e));
		wr(8'h02, 8'h00);
		repeat (6) @(posedge sys_clk);
		#1 chk(8'(req[l]), 8'(!e));
		take(l);
		rd(8'h04, 8'h05 << l);
		chk(8'(event_irq), 8'h00);
	endtask : run

	task end_of_test;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt = error_cnt + 1;
			end_of_test();
		end
	end

	initial
	begin
		seed      = 32'h1020;
		error_cnt = 0;
		tests_run = 0;
		rstn      = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		tk        = 2'b00;
		rs[0]     = 2'b00;
		rs[1]     = 2'b00;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h50);
		rd(8'h03, 8'h03);
		rd(8'h05, 8'h00);
		rd(8'h9A, 8'h00);
		for (int l = 0; l < 2; l++)
			for (int e = 0; e < 2; e++)
				run(l, e[0]);
		wr(8'h00, 8'h00);
		wr(8'h01, 8'h00);
		repeat (16)
		begin
			@(posedge sys_clk);
			rs[0] <= 2'($random(seed));
			rs[1] <= 2'($random(seed));
			@(posedge sys_clk);
			rs[0] <= 2'b00;
			rs[1] <= 2'b00;
			repeat (4) @(posedge sys_clk);
			rd(8'h03, {6'h00, m_n, x_n});
			@(posedge sys_clk);
			tk <= 2'($random(seed));
			@(posedge sys_clk);
			tk <= 2'b00;
			wr(8'h02, 8'h00);
		end
		end_of_test();
	end
endmodule : tb_external_interrupt_pins
